// ==== rtl/fpiog_top.v ====
// Floppy and printer I/O glue: DMA routing, clocks, port decode, precompensation
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpiog_defs.vh"

// How it works
// - Terminal count to controller follows DMA count
// - Controller DMA request forwarded as channel-2 request
// - Active-low acknowledge presented to the controller
// - Precompensation acts only with its enable input high
// - Controller interrupt becomes interrupt request six
// - DMA-active input suppresses all port decoding
// - Switch low printer port, high floppy port
// - Two base clocks, 16 and 19.2 MHz
// - Controller clock frequency follows the selected rate
// - Separator clock 8, 9.6 or 8 MHz
// - Write clock derived from controller clock by eight
// - Controller select low on ports 3F4H, 3F5H
// - Controller reset from bit D2 at 3F2H
// - Disk-change strobe low on read of 3F7H
// - Write data shifted per two precompensation inputs
// - Separator read follows sync control level
// - Printer interrupt enable written at port 372H
// - Serial select low for ports 3F8H-3FFH
// - Two motor outputs written at port 3F2H
// - Rate output high for 300 kbps, from 3F7H
// - Printer busy, strobe at 371H; select at 3F7H
// - External mode remaps busy, select, autofeed lines
module fpiog_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // DMA and interrupt path
  input  wire        dma_terminal_count_in,
  output reg         fdc_terminal_count_out,
  input  wire        fdc_dma_request_in,
  output reg         dma_request_ch2_out,
  input  wire        dma_ack_ch2_n,
  output reg         fdc_dma_ack_n,
  input  wire        controller_interrupt_in,
  output reg         irq6_out,
  input  wire        dma_active_decode_inhibit,
  // Base clocks, sampled as ordinary inputs
  input  wire        base_clock_a,
  input  wire        base_clock_b,
  output reg         controller_clock_out,
  output reg         separator_clock_out,
  output reg         write_clock_out,
  // Port selects and strobes
  output reg         controller_select_n,
  output reg         primary_serial_select_n,
  output reg         disk_change_read_n,
  // Drive control
  output reg         controller_reset_out,
  output reg         motor_on_first,
  output reg         motor_on_second,
  output reg         rate_select_out,
  output reg         printer_int_enable_n,
  // Write path and separator
  input  wire        precomp_enable_in,
  input  wire        precomp_ctl_lo,
  input  wire        precomp_ctl_hi,
  input  wire        controller_write_data_in,
  input  wire        controller_write_enable_in,
  output reg         write_data_out,
  input  wire        sync_ctl_in,
  output reg         separator_read_enable,
  // Shared connector
  input  wire        external_drive_switch,
  input  wire        printer_busy_level,
  input  wire        printer_strobe_level,
  input  wire        printer_select_n_level,
  input  wire        printer_autofeed_level,
  output reg         ext_motor_on,
  output reg         ext_write_gate,
  output reg         ext_low_density
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Exact match of a port index
  function port_hit;
    input [9:0] idx;
    input [9:0] port;
    begin
      port_hit = (idx == port);
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------

  localparam [1:0] ST_IDLE = 2'b01;  // Waiting for a request
  localparam [1:0] ST_DONE = 2'b10;  // Answer cycle, waitrequest low

  reg  [1:0] st_reg;                 // One-hot bus state
  reg  [1:0] st_next;                // Next bus state
  reg  [7:0] drv_ctrl_reg;           // Drive control port contents
  reg  [7:0] prt_ctrl_reg;           // Printer control port contents
  reg  [1:0] rate_reg;               // Selected transfer rate code
  wire [9:0] idx;                    // Port index from byte address
  wire       req;                    // Live request
  wire       dec_ok;                 // Decoding allowed
  wire       ser_hit;                // Serial range hit
  wire       fdc_hit;                // Controller ports hit

  assign idx     = avs_address[11:2];
  assign req     = avs_read | avs_write;
  assign dec_ok  = req & ~dma_active_decode_inhibit;
  assign ser_hit = ((idx & `FPIOG_SER_MASK) == `FPIOG_SER_BASE);
  assign fdc_hit = port_hit(idx, `FPIOG_PORT_FDC_MAIN) | port_hit(idx, `FPIOG_PORT_FDC_DATA);

  // Next state: one wait cycle, then one answer cycle
  always @* begin
    case (st_reg)
      ST_IDLE: begin
        st_next = req ? ST_DONE : ST_IDLE;
      end
      ST_DONE: begin
        st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // Read data mux; unmapped or inhibited reads give zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (dec_ok) begin
      if (port_hit(idx, `FPIOG_PORT_PRT_STATUS)) begin
        rd_byte[`FPIOG_STS_BUSY_BIT]   = printer_busy_level;
        rd_byte[`FPIOG_STS_STROBE_BIT] = printer_strobe_level;
      end else if (port_hit(idx, `FPIOG_PORT_PRT_CTRL)) begin
        rd_byte = prt_ctrl_reg;
      end else if (port_hit(idx, `FPIOG_PORT_DRV_CTRL)) begin
        rd_byte = drv_ctrl_reg;
      end else if (port_hit(idx, `FPIOG_PORT_RATE)) begin
        rd_byte[0] = printer_select_n_level;
      end
    end
  end

  // Bus handshake and register writes
  // Writes land at the edge that raises the answer; the master sees it one edge later
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg          <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      drv_ctrl_reg    <= `FPIOG_DRV_CTRL_RST;
      prt_ctrl_reg    <= `FPIOG_PRT_CTRL_RST;
      rate_reg        <= `FPIOG_RATE_RST;
    end else begin
      st_reg          <= st_next;
      avs_waitrequest <= ~(st_reg[0] & req);
      if (st_reg[0] & req) begin
        avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        // Only byte lane 0 carries port data
        if (avs_write & avs_byteenable[0] & dec_ok) begin
          if (port_hit(idx, `FPIOG_PORT_DRV_CTRL)) begin
            drv_ctrl_reg <= avs_writedata[7:0];
          end
          if (port_hit(idx, `FPIOG_PORT_PRT_CTRL)) begin
            prt_ctrl_reg <= avs_writedata[7:0];
          end
          if (port_hit(idx, `FPIOG_PORT_RATE)) begin
            rate_reg <= avs_writedata[`FPIOG_RATE_SEL_LSB+1:`FPIOG_RATE_SEL_LSB];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Port selects and control outputs
  // ----------------------------------------------------------------

  // Selects stand low for the answer cycle only of a decoded access
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      controller_select_n     <= 1'b1;
      primary_serial_select_n <= 1'b1;
      disk_change_read_n      <= 1'b1;
      controller_reset_out    <= 1'b0;
      motor_on_first          <= 1'b0;
      motor_on_second         <= 1'b0;
      rate_select_out         <= 1'b0;
      printer_int_enable_n    <= 1'b1;
    end else begin
      controller_select_n     <= ~(dec_ok & fdc_hit & ~st_reg[1]);
      primary_serial_select_n <= ~(dec_ok & ser_hit & ~st_reg[1]);
      disk_change_read_n      <= ~(dec_ok & avs_read & ~st_reg[1]
                                   & port_hit(idx, `FPIOG_PORT_RATE));
      controller_reset_out    <= drv_ctrl_reg[`FPIOG_DRV_RESET_BIT];
      motor_on_first          <= drv_ctrl_reg[`FPIOG_DRV_MOTOR_A_BIT];
      motor_on_second         <= drv_ctrl_reg[`FPIOG_DRV_MOTOR_B_BIT];
      rate_select_out         <= (rate_reg == `FPIOG_RATE_300);
      printer_int_enable_n    <= ~prt_ctrl_reg[`FPIOG_PRT_INTEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // DMA and interrupt routing
  // ----------------------------------------------------------------

  // One register stage each, so every output is a flop
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fdc_terminal_count_out <= 1'b0;
      dma_request_ch2_out    <= 1'b0;
      fdc_dma_ack_n          <= 1'b1;
      irq6_out               <= 1'b0;
    end else begin
      fdc_terminal_count_out <= dma_terminal_count_in;
      dma_request_ch2_out    <= fdc_dma_request_in;
      fdc_dma_ack_n          <= dma_ack_ch2_n;
      irq6_out               <= controller_interrupt_in;
    end
  end

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------

  reg       clk_a_q;                 // Sampled 16 MHz base
  reg       clk_b_q;                 // Sampled 19.2 MHz base
  reg [1:0] div_a_reg;               // Divider on 16 MHz edges
  reg [1:0] div_b_reg;               // Divider on 19.2 MHz edges
  reg [2:0] wdiv_reg;                // Write clock divider
  reg       ctl_clk_next;            // Selected controller clock
  reg       sep_clk_next;            // Selected separator clock

  // Base edges are the live input high against its sampled copy low; jitter is one sys_clk
  // two base clocks
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_a_q   <= 1'b0;
      clk_b_q   <= 1'b0;
      div_a_reg <= 2'h0;
      div_b_reg <= 2'h0;
    end else begin
      clk_a_q <= base_clock_a;
      clk_b_q <= base_clock_b;
      if (base_clock_a & ~clk_a_q) begin
        div_a_reg <= div_a_reg + 2'h1;
      end
      if (base_clock_b & ~clk_b_q) begin
        div_b_reg <= div_b_reg + 2'h1;
      end
    end
  end

  // Rate-dependent selection of the divided clocks
  always @* begin
    case (rate_reg)
      // 300 kbps: 4.8 and 9.6 MHz
      `FPIOG_RATE_300: begin
        ctl_clk_next = div_b_reg[1];
        sep_clk_next = div_b_reg[0];
      end
      // 250 kbps: 8 and 8 MHz
      `FPIOG_RATE_250: begin
        ctl_clk_next = div_a_reg[0];
        sep_clk_next = div_a_reg[0];
      end
      // 500 kbps and the spare code: 4 and 8 MHz
      default: begin
        ctl_clk_next = div_a_reg[1];
        sep_clk_next = div_a_reg[0];
      end
    endcase
  end

  // Clock outputs and write clock
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      controller_clock_out <= 1'b0;
      separator_clock_out  <= 1'b0;
      write_clock_out      <= 1'b0;
      wdiv_reg             <= 3'h0;
    end else begin
      controller_clock_out <= ctl_clk_next;
      separator_clock_out  <= sep_clk_next;
      if (ctl_clk_next & ~controller_clock_out) begin
        wdiv_reg <= wdiv_reg + 3'h1;
      end
      write_clock_out <= wdiv_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Write precompensation and separator
  // ----------------------------------------------------------------

  reg [`FPIOG_PRECOMP_LEN-1:0] wd_line_reg;  // Write data delay line
  reg                          wd_tap;       // Selected tap

  // Nominal timing is the middle tap, so an advance is the direct input
  // tap by precomp inputs
  always @* begin
    wd_tap = wd_line_reg[`FPIOG_PRECOMP_CYC-1];
    if (precomp_enable_in) begin
      if (~precomp_ctl_lo & precomp_ctl_hi) begin
        wd_tap = wd_line_reg[`FPIOG_PRECOMP_LEN-1];
      end else if (precomp_ctl_lo & ~precomp_ctl_hi) begin
        wd_tap = controller_write_data_in;
      end
    end
  end

  // Delay line, write data and separator control
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_line_reg           <= {`FPIOG_PRECOMP_LEN{1'b0}};
      write_data_out        <= 1'b0;
      separator_read_enable <= 1'b0;
    end else begin
      wd_line_reg    <= {wd_line_reg[`FPIOG_PRECOMP_LEN-2:0], controller_write_data_in};
      write_data_out <= wd_tap & controller_write_enable_in;
      separator_read_enable <= sync_ctl_in;
    end
  end

  // ----------------------------------------------------------------
  // Shared connector
  // ----------------------------------------------------------------

  // Printer lines take drive meaning only with the switch high
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_motor_on    <= 1'b0;
      ext_write_gate  <= 1'b0;
      ext_low_density <= 1'b0;
    end else begin
      ext_motor_on    <= external_drive_switch & printer_busy_level;
      ext_write_gate  <= external_drive_switch & printer_select_n_level;
      ext_low_density <= external_drive_switch & printer_autofeed_level;
    end
  end

endmodule
`default_nettype wire

// ==== shared/fpiog_defs.vh ====
// Constants for the floppy and printer I/O glue block
`ifndef FPIOG_DEFS_VH
`define FPIOG_DEFS_VH

// ----------------------------------------------------------------
// Port indexes (byte address on the bus is four times the index)
// ----------------------------------------------------------------
`define FPIOG_PORT_PRT_STATUS 10'h371
`define FPIOG_PORT_PRT_CTRL   10'h372
`define FPIOG_PORT_DRV_CTRL   10'h3f2
`define FPIOG_PORT_FDC_MAIN   10'h3f4
`define FPIOG_PORT_FDC_DATA   10'h3f5
`define FPIOG_PORT_RATE       10'h3f7
`define FPIOG_SER_BASE        10'h3f8
`define FPIOG_SER_MASK        10'h3f8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FPIOG_DRV_RESET_BIT   2
`define FPIOG_DRV_MOTOR_A_BIT 4
`define FPIOG_DRV_MOTOR_B_BIT 5
`define FPIOG_PRT_INTEN_BIT   4
`define FPIOG_STS_BUSY_BIT    7
`define FPIOG_STS_STROBE_BIT  0
`define FPIOG_RATE_SEL_LSB    0

// ----------------------------------------------------------------
// Rate codes and reset values
// ----------------------------------------------------------------
`define FPIOG_RATE_500        2'h0
`define FPIOG_RATE_300        2'h1
`define FPIOG_RATE_250        2'h2
`define FPIOG_DRV_CTRL_RST    8'h00
`define FPIOG_PRT_CTRL_RST    8'h00
`define FPIOG_RATE_RST        2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPIOG_CLK_PERIOD_NS   10
`define FPIOG_PRECOMP_MIN_NS  225
`define FPIOG_PRECOMP_MAX_NS  250
`define FPIOG_PRECOMP_CYC     (((`FPIOG_PRECOMP_MIN_NS + `FPIOG_PRECOMP_MAX_NS) / 2) / `FPIOG_CLK_PERIOD_NS)
`define FPIOG_PRECOMP_LEN     (2 * `FPIOG_PRECOMP_CYC)

`endif

// ==== verification/fpiog_chk_asserts.sv ====
// Concurrent checks on the floppy and printer glue ports
`timescale 1ns/1ps
`default_nettype none
module fpiog_chk (
  // Clock, reset and bus
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // DMA and interrupt path
  input wire logic        dma_terminal_count_in,
  input wire logic        fdc_terminal_count_out,
  input wire logic        fdc_dma_request_in,
  input wire logic        dma_request_ch2_out,
  input wire logic        dma_ack_ch2_n,
  input wire logic        fdc_dma_ack_n,
  input wire logic        controller_interrupt_in,
  input wire logic        irq6_out,
  input wire logic        dma_active_decode_inhibit,
  // Selects, separator and connector
  input wire logic        controller_select_n,
  input wire logic        primary_serial_select_n,
  input wire logic        disk_change_read_n,
  input wire logic        sync_ctl_in,
  input wire logic        separator_read_enable,
  input wire logic        external_drive_switch,
  input wire logic        ext_motor_on,
  input wire logic        ext_write_gate,
  input wire logic        ext_low_density
);
  logic [9:0] idx;    // Port index of the access
  logic       req_d;  // Request seen last cycle
  logic       fresh;  // New request with decode on
  assign idx   = avs_address[11:2];
  assign fresh = (avs_read || avs_write) && !req_d && !dma_active_decode_inhibit;
  // Edge finder kept as a flop so no sampled function sits in an assign
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_d <= 1'b0;
    end else begin
      req_d <= avs_read || avs_write;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property ((avs_read || avs_write) && !req_d |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  a_tc_follow: assert property (1'b1 |=> fdc_terminal_count_out == $past(dma_terminal_count_in))
    else $error("terminal count does not follow");
  a_drq_follow: assert property ($rose(fdc_dma_request_in) |=> dma_request_ch2_out)
    else $error("channel request not forwarded");
  a_ack_pass: assert property ($fell(dma_ack_ch2_n) |=> $fell(fdc_dma_ack_n))
    else $error("acknowledge not passed through");
  a_irq_follow: assert property (controller_interrupt_in |=> irq6_out)
    else $error("interrupt six not raised");
  a_inhibit_quiet: assert property (dma_active_decode_inhibit [*3] |->
    controller_select_n && primary_serial_select_n && disk_change_read_n)
    else $error("select active while decode inhibited");
  a_fdc_select: assert property (fresh && idx[9:1] == 9'h1fa |-> ##[1:2] !controller_select_n)
    else $error("controller select missing");
  a_serial_sel: assert property (fresh && idx[9:3] == 7'h7f |-> ##[1:2] !primary_serial_select_n)
    else $error("serial select missing");
  a_change_read: assert property (fresh && avs_read && idx == 10'h3f7 |-> ##[1:2] !disk_change_read_n)
    else $error("disk change strobe missing");
  a_sep_read: assert property ($changed(sync_ctl_in) |=> separator_read_enable == $past(sync_ctl_in))
    else $error("separator read enable wrong");
  a_local_mode: assert property (!external_drive_switch [*2] |->
    !ext_motor_on && !ext_write_gate && !ext_low_density)
    else $error("external lines active in printer mode");
  c_fdc_sel: cover property (fresh && idx == 10'h3f5);
  c_dma_ack: cover property (!fdc_dma_ack_n && fdc_terminal_count_out);
  c_ext_mode: cover property (external_drive_switch && ext_motor_on);
endmodule
bind fpiog_top fpiog_chk u_chk (.*);
`default_nettype wire

// ==== verification/fpiog_fdc_model.sv ====
// Behavioural floppy controller and DMA channel facing the glue block
`timescale 1ns/1ps
`default_nettype none
module fpiog_fdc_model (
  // Clock and command
  input  wire logic clk,
  input  wire logic go,      // Start one DMA byte
  input  wire logic slow,    // Stretch the wait before acknowledge
  // Toward the glue block
  output var logic  drq,
  output var logic  dack_n,
  output var logic  tc,
  output var logic  intr
);
  int unsigned cnt;  // Cycles left before acknowledge
  initial begin
    drq = 1'b0;
    dack_n = 1'b1;
    tc = 1'b0;
    intr = 1'b0;
    cnt = 0;
  end
  // Request, wait, one-cycle acknowledge with count end, then interrupt held
  always @(posedge clk) begin
    if (go && !drq) begin
      drq <= 1'b1;
      intr <= 1'b0;
      cnt <= slow ? 12 : 1;
    end else if (drq && cnt != 0) begin
      cnt <= cnt - 1;
    end else if (drq) begin
      drq <= 1'b0;
      dack_n <= 1'b0;
      tc <= 1'b1;
      intr <= 1'b1;
    end else begin
      dack_n <= 1'b1;
      tc <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the floppy and printer glue block
`timescale 1ns/1ps
`default_nettype none
`include "fpiog_defs.vh"
module testbench;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, dma_go, dma_slow;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic        dma_terminal_count_in, fdc_terminal_count_out, fdc_dma_request_in;
  logic        dma_request_ch2_out, dma_ack_ch2_n, fdc_dma_ack_n, controller_interrupt_in;
  logic        irq6_out, dma_active_decode_inhibit, base_clock_a, base_clock_b;
  logic        controller_clock_out, separator_clock_out, write_clock_out;
  logic        controller_select_n, primary_serial_select_n, disk_change_read_n;
  logic        controller_reset_out, motor_on_first, motor_on_second, rate_select_out;
  logic        printer_int_enable_n, precomp_enable_in, precomp_ctl_lo, precomp_ctl_hi;
  logic        controller_write_data_in, controller_write_enable_in, write_data_out;
  logic        sync_ctl_in, separator_read_enable, external_drive_switch;
  logic        printer_busy_level, printer_strobe_level, printer_select_n_level;
  logic        printer_autofeed_level, ext_motor_on, ext_write_gate, ext_low_density;
  int          err_total, checks;
  fpiog_top uut (.*);
  fpiog_fdc_model fdc_far (.clk(sys_clk), .go(dma_go), .slow(dma_slow),
    .drq(fdc_dma_request_in), .dack_n(dma_ack_ch2_n), .tc(dma_terminal_count_in),
    .intr(controller_interrupt_in));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A wait that ran out of its bound ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      end_of_test;
    end
  endtask
  // One bus access: held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    tmo(n, 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Drive control, printer ports and selects
  task automatic t_regs;
    bus(0, 10'h3f2, 8'h00);
    chk(rd, 32'h0);
    bus(1, 10'h3f2, 8'h34);
    chk({controller_reset_out, motor_on_first, motor_on_second}, 3'b111);
    bus(0, 10'h3f2, 8'h00);
    chk(rd, 32'h34);
    bus(1, 10'h3f2, 8'h20);
    chk({controller_reset_out, motor_on_first, motor_on_second}, 3'b001);
    bus(1, 10'h372, 8'h10);
    chk(printer_int_enable_n, 1'b0);
    bus(0, 10'h372, 8'h00);
    chk(rd, 32'h10);
    bus(1, 10'h372, 8'h00);
    chk(printer_int_enable_n, 1'b1);
    bus(0, 10'h371, 8'h00);
    chk(rd, 32'h81);
    printer_strobe_level <= 1'b0;
    bus(0, 10'h3f7, 8'h00);
    chk(rd, 32'h01);
    bus(0, 10'h371, 8'h00);
    chk(rd, 32'h80);
    bus(0, 10'h3f4, 8'h00);
    bus(1, 10'h3f5, 8'h00);
    bus(0, 10'h3fb, 8'h00);
    bus(0, 10'h300, 8'h00);
  endtask
  // Decode held off while DMA owns the bus
  task automatic t_inhibit;
    dma_active_decode_inhibit <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(1, 10'h3f2, 8'h10);
    chk(motor_on_first, 1'b0);
    bus(0, 10'h3f7, 8'h00);
    chk(rd, 32'h0);
    dma_active_decode_inhibit <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Every rate code; rising edges counted over 20 us
  task automatic t_rates;
    int a, b, w, ec;
    logic [2:0] p, q;
    for (int code = 0; code < 4; code++) begin
      bus(1, 10'h3f7, 8'(code));
      chk(rate_select_out, code == 1);
      ec = (code == 1) ? 96 : (code == 2) ? 160 : 80;
      a = 0;
      b = 0;
      w = 0;
      p = {controller_clock_out, separator_clock_out, write_clock_out};
      repeat (2000) begin
        @(posedge sys_clk);
        q = {controller_clock_out, separator_clock_out, write_clock_out};
        a += int'(q[2] & ~p[2]);
        b += int'(q[1] & ~p[1]);
        w += int'(q[0] & ~p[0]);
        p = q;
      end
      chk(a >= ec - 1 && a <= ec + 1, 1'b1);
      chk(b >= ((code == 1) ? 191 : 159) && b <= ((code == 1) ? 193 : 161), 1'b1);
      chk(w >= ec / 8 - 1 && w <= ec / 8 + 1, 1'b1);
    end
  endtask
  // DMA handshake, prompt and stalled
  task automatic t_dma;
    int n;
    for (int s = 0; s < 2; s++) begin
      dma_slow <= s[0];
      dma_go <= 1'b1;
      @(posedge sys_clk);
      dma_go <= 1'b0;
      for (n = 0; n < 40 && dma_request_ch2_out !== 1'b1; n++)
        @(posedge sys_clk);
      tmo(n, 40);
      chk(fdc_dma_ack_n, 1'b1);
      for (n = 0; n < 40 && fdc_dma_ack_n !== 1'b0; n++)
        @(posedge sys_clk);
      tmo(n, 40);
      chk({fdc_terminal_count_out, dma_request_ch2_out, irq6_out}, 3'b101);
      @(posedge sys_clk);
      chk({fdc_dma_ack_n, fdc_terminal_count_out}, 2'b10);
    end
  endtask
  // Write data delay per precompensation code; last case has write enable low
  task automatic t_precomp;
    int n, d[5];
    logic [14:0] modes;
    modes = 15'b100_101_110_001_100;
    for (int k = 0; k < 5; k++) begin
      {precomp_enable_in, precomp_ctl_lo, precomp_ctl_hi} <= modes[14 - 3 * k -: 3];
      controller_write_enable_in <= (k < 4);
      // Gap outlasts the whole delay line, so no earlier pulse reaches the tap
      repeat (50) @(posedge sys_clk);
      controller_write_data_in <= 1'b1;
      @(posedge sys_clk);
      controller_write_data_in <= 1'b0;
      for (n = 1; n < 80 && write_data_out !== 1'b1; n++)
        @(posedge sys_clk);
      if (k < 4) tmo(n, 80);
      d[k] = n;
    end
    chk(d[1] - d[0], `FPIOG_PRECOMP_CYC);
    chk(d[0] - d[2], `FPIOG_PRECOMP_CYC);
    chk(d[3], d[0]);
    chk(d[4], 80);
  endtask
  // Separator enable and shared connector remap
  task automatic t_conn;
    sync_ctl_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(separator_read_enable, 1'b1);
    sync_ctl_in <= 1'b0;
    external_drive_switch <= 1'b1;
    {printer_busy_level, printer_select_n_level, printer_autofeed_level} <= 3'b101;
    repeat (3) @(posedge sys_clk);
    chk(separator_read_enable, 1'b0);
    chk({ext_motor_on, ext_write_gate, ext_low_density}, 3'b101);
    {printer_busy_level, printer_select_n_level, printer_autofeed_level} <= 3'b010;
    repeat (3) @(posedge sys_clk);
    chk({ext_motor_on, ext_write_gate, ext_low_density}, 3'b010);
    external_drive_switch <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({ext_motor_on, ext_write_gate, ext_low_density}, 3'b000);
  endtask
  // Clocks: system, then the two free-running base oscillators
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    base_clock_a = 1'b0;
    forever #31.25 base_clock_a = ~base_clock_a;
  end
  initial begin
    base_clock_b = 1'b0;
    forever #26.042 base_clock_b = ~base_clock_b;
  end
  // Main sequence
  initial begin
    {sys_rst, avs_byteenable, printer_busy_level, printer_strobe_level} = 7'b1_0001_11;
    {avs_read, avs_write, avs_address, avs_writedata, dma_go, dma_slow} = '0;
    {dma_active_decode_inhibit, precomp_enable_in, precomp_ctl_lo, precomp_ctl_hi} = '0;
    {controller_write_data_in, controller_write_enable_in, sync_ctl_in} = '0;
    {external_drive_switch, printer_autofeed_level, printer_select_n_level} = 3'b001;
    err_total = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_inhibit;
    t_rates;
    t_dma;
    t_precomp;
    t_conn;
    end_of_test;
  end
endmodule
`default_nettype wire
